/* rcs_far_side.sv */
/*
  Far-side model: the fast oscillator, the bus crystal and a processor
  that holds I/O commands and signals shutdown on bench request.
  Assumes the processor clock comes from the block under test.
*/
`timescale 1ns/100ps
`default_nettype none
module rcs_far_side #(
  parameter int FAST_HALF_NS = 32,
  parameter int XTAL_HALF_NS = 88
) (
  input wire logic processor_clock_in,
  input wire logic io_hold_in,
  input wire logic shutdown_req_in,
  output logic fast_clock_out,
  output logic bus_crystal_clock_out,
  output logic io_command_active_out,
  output logic shutdown_out
);
  // Free-running oscillators, phases unrelated to the system clock
  initial begin
    fast_clock_out = 1'b0;
    #5;
    forever #FAST_HALF_NS fast_clock_out = ~fast_clock_out;
  end
  initial begin
    bus_crystal_clock_out = 1'b0;
    #13;
    forever #XTAL_HALF_NS bus_crystal_clock_out = ~bus_crystal_clock_out;
  end
  // Processor status changes on its own clock fall, like the real part
  initial begin
    io_command_active_out = 1'b0;
    shutdown_out = 1'b0;
    forever begin
      @(negedge processor_clock_in);
      io_command_active_out <= io_hold_in;
      shutdown_out <= shutdown_req_in;
    end
  end
endmodule
`default_nettype wire

/* rcs_pkg.sv */
/*
  Package for the reset and clock select block: register map, field
  positions, reset values, timing counts and the bus request carrier.
  Assumes a 32-bit APB master on the same clock as the block.
*/
package rcs_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam logic [11:0] RCS_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] RCS_SEL_OFFSET = 12'h004;
  localparam logic [11:0] RCS_STAT_OFFSET = 12'h008;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int RCS_CLOCK_SWITCH_POS = 4;
  localparam int RCS_CPU_RESET_REQ_POS = 5;
  localparam int RCS_SEL_LSB = 0;
  localparam int RCS_SEL_MSB = 1;
  localparam int RCS_STAT_CPU_RESET_POS = 0;
  localparam int RCS_STAT_SYS_RESET_POS = 1;
  localparam int RCS_STAT_ON_SLOW_POS = 2;
  localparam int RCS_STAT_BUSY_POS = 3;
  localparam int RCS_STAT_SOFT_PEND_POS = 4;

  // ******************************************************************
  // Bus state clock selections and reset values
  // ******************************************************************
  localparam logic [1:0] RCS_BSEL_FAST = 2'h0;
  localparam logic [1:0] RCS_BSEL_FAST_HALF = 2'h1;
  localparam logic [1:0] RCS_BSEL_CRYSTAL = 2'h2;
  localparam logic [1:0] RCS_SEL_RESET = RCS_BSEL_FAST_HALF;
  localparam logic RCS_SWITCH_RESET = 1'b0;

  // ******************************************************************
  // Timing counts, in processor clock cycles, and the reset counter width
  // ******************************************************************
  localparam int RCS_CPU_RESET_CYCLES = 16;
  localparam int RCS_RESET_CNT_W = 6;

  // ******************************************************************
  // APB request carrier
  // ******************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcs_apb_req_type;

endpackage

/* rcs_reset_clock_select.sv */
/*
  Reset generation and processor / bus clock selection. All pins and
  both input clocks are oversampled on clk_in and resynchronised; the
  generated clocks are therefore registered levels, so both input clocks
  must run well below half the rate of clk_in.
  Assumes an APB master on clk_in and synchronous active-high rst_in.
*/
`timescale 1ns/100ps
`default_nettype none

// Function
// - Power bad asserts CPU and system reset
// - Warm reset asserts CPU reset only
// - Shutdown asserts CPU reset on processor edge
// - Soft request resets CPU after command idle
// - CPU reset lasts at least sixteen clocks
// - System reset synchronous, held while power bad
// - Two input clocks, software picks processor source
// - Phase clock is half processor clock
// - Bus system clock is half bus clock
// - Synchronous mode derives clocks from fast input
// - Asynchronous mode bus clock from crystal input
// - Select field then switch bit; fast default
// - No short or long processor clock phase
// - Fast to slow: two falling edges remove fast
// - Bus clock rise latches, fall enables it
// - Resample processor clock low before enabling
// - Slow to fast: rising latch, next removes
// - Fast edge latches low, next enables fast
// - Missed low sample retried on next edge
module rcs_reset_clock_select #(
  parameter int CPU_RESET_CYCLES = rcs_pkg::RCS_CPU_RESET_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire rcs_pkg::rcs_apb_req_type apb_req_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic power_good_in,
  input wire logic warm_reset_in,
  input wire logic shutdown_in,
  input wire logic io_command_active_in,
  input wire logic fast_clock_in,
  input wire logic bus_crystal_clock_in,
  output logic cpu_reset_out,
  output logic system_reset_out,
  output logic processor_clock_out,
  output logic phase_clock_out,
  output logic bus_state_clock_out,
  output logic bus_system_clock_out
);
  import rcs_pkg::*;

  typedef enum logic [2:0] {
    ST_FAST, ST_F_CMD, ST_F_GAP, ST_S_ARM,
    ST_SLOW, ST_S_CMD, ST_S_GAP, ST_F_ARM
  } rcs_state_type;

  localparam int NPIN = 6;
  localparam logic [RCS_RESET_CNT_W-1:0] RST_LOAD = RCS_RESET_CNT_W'(CPU_RESET_CYCLES);
  localparam logic [RCS_RESET_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [RCS_RESET_CNT_W-1:0] CNT_ONE = RCS_RESET_CNT_W'(1);

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_reg;
  logic [NPIN-1:0] s2_reg;
  logic [NPIN-1:0] s3_reg;

  assign pin_raw = {bus_crystal_clock_in, fast_clock_in, io_command_active_in,
                    shutdown_in, warm_reset_in, power_good_in};

  // Three stages per pin; only the last two feed edge logic
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
        end else begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
        end
      end
    end
  endgenerate

  logic pwr_bad;
  logic warm_rise;
  logic shut_rise;
  logic io_active;
  logic fast_lvl;
  logic fast_rise;
  logic fast_fall;
  logic xtal_lvl;

  // Two-stage synchronised levels and edges
  assign pwr_bad = ~s2_reg[0];
  assign warm_rise = s2_reg[1] & ~s3_reg[1];
  assign shut_rise = s2_reg[2] & ~s3_reg[2];
  assign io_active = s2_reg[3];
  assign fast_lvl = s2_reg[4];
  assign fast_rise = s2_reg[4] & ~s3_reg[4];
  assign fast_fall = ~s2_reg[4] & s3_reg[4];
  assign xtal_lvl = s2_reg[5];

  // ******************************************************************
  // Register file
  // ******************************************************************
  logic switch_reg;
  logic [1:0] bsel_reg;
  logic soft_req_reg;
  logic [31:0] prdata_reg;
  logic wr_en;
  logic setup_ph;
  logic mapped;
  logic [31:0] rd_word;
  logic soft_pend_reg;
  logic shut_pend_reg;
  logic [RCS_RESET_CNT_W-1:0] rst_cnt_reg;
  logic cpu_reset_reg;
  logic sys_reset_reg;
  rcs_state_type st_reg;
  rcs_state_type st_next;

  assign setup_ph = apb_req_in.psel & ~apb_req_in.penable;
  assign wr_en = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite & mapped;
  assign mapped = (apb_req_in.paddr == RCS_CTRL_OFFSET) |
                  (apb_req_in.paddr == RCS_SEL_OFFSET) |
                  (apb_req_in.paddr == RCS_STAT_OFFSET);
  assign pready_out = 1'b1;
  assign pslverr_out = apb_req_in.psel & apb_req_in.penable & ~mapped;
  assign prdata_out = prdata_reg;

  // Read mux; unused bits read as zero
  always_comb begin
    rd_word = 32'h00000000;
    if (apb_req_in.paddr == RCS_CTRL_OFFSET) begin
      rd_word[RCS_CLOCK_SWITCH_POS] = switch_reg;
      rd_word[RCS_CPU_RESET_REQ_POS] = soft_req_reg;
    end else if (apb_req_in.paddr == RCS_SEL_OFFSET) begin
      rd_word[RCS_SEL_MSB:RCS_SEL_LSB] = bsel_reg;
    end else if (apb_req_in.paddr == RCS_STAT_OFFSET) begin
      rd_word[RCS_STAT_CPU_RESET_POS] = cpu_reset_reg;
      rd_word[RCS_STAT_SYS_RESET_POS] = sys_reset_reg;
      rd_word[RCS_STAT_ON_SLOW_POS] = (st_reg == ST_SLOW);
      rd_word[RCS_STAT_BUSY_POS] = (st_reg != ST_SLOW) && (st_reg != ST_FAST);
      rd_word[RCS_STAT_SOFT_PEND_POS] = soft_pend_reg;
    end
  end

  // Read data captured in the setup phase, stable through access
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_ph) begin
      prdata_reg <= rd_word;
    end
  end

  // Writable fields; switch bit should follow the select field
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      switch_reg <= RCS_SWITCH_RESET;
      bsel_reg <= RCS_SEL_RESET;
      soft_req_reg <= 1'b0;
    end else if (wr_en && apb_req_in.paddr == RCS_CTRL_OFFSET) begin
      switch_reg <= apb_req_in.pwdata[RCS_CLOCK_SWITCH_POS];
      soft_req_reg <= apb_req_in.pwdata[RCS_CPU_RESET_REQ_POS];
    end else if (wr_en && apb_req_in.paddr == RCS_SEL_OFFSET) begin
      bsel_reg <= apb_req_in.pwdata[RCS_SEL_MSB:RCS_SEL_LSB];
    end
  end

  // ******************************************************************
  // Bus state clock and processor clock generation
  // ******************************************************************
  logic half_fast_reg;
  logic bclk_src;
  logic bclk_reg;
  logic bclk_prev_reg;
  logic bclk_rise;
  logic bclk_fall;
  logic proc_next;
  logic proc_reg;
  logic proc_prev_reg;
  logic proc_rise;
  logic proc_fall;
  logic phase_reg;
  logic bus_sys_clk_reg;

  // Half-rate copy of the fast input
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      half_fast_reg <= 1'b0;
    end else if (fast_rise) begin
      half_fast_reg <= ~half_fast_reg;
    end
  end

  // Bus state clock source; reserved code falls back to half fast
  always_comb begin
    case (bsel_reg)
      RCS_BSEL_FAST: bclk_src = fast_lvl;
      RCS_BSEL_FAST_HALF: bclk_src = half_fast_reg;
      RCS_BSEL_CRYSTAL: bclk_src = xtal_lvl;
      default: bclk_src = half_fast_reg;
    endcase
  end

  assign bclk_rise = bclk_reg & ~bclk_prev_reg;
  assign bclk_fall = ~bclk_reg & bclk_prev_reg;
  assign proc_rise = proc_reg & ~proc_prev_reg;
  assign proc_fall = ~proc_reg & proc_prev_reg;

  // Switch sequencer; every handover passes a held-low gap
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_FAST: if (switch_reg && proc_fall && !io_active) st_next = ST_F_CMD;
      ST_F_CMD: if (proc_fall) st_next = ST_F_GAP;
      ST_F_GAP: if (bclk_rise && !proc_reg) st_next = ST_S_ARM;
      ST_S_ARM: if (bclk_fall) st_next = ST_SLOW;
      ST_SLOW: if (!switch_reg && proc_rise && !io_active) st_next = ST_S_CMD;
      ST_S_CMD: if (proc_fall) st_next = ST_S_GAP;
      ST_S_GAP: if (fast_rise && !proc_reg) st_next = ST_F_ARM;
      ST_F_ARM: if (fast_fall) st_next = ST_FAST;
      default: st_next = ST_FAST;
    endcase
  end

  // Output level follows the next state so a cut lands while low
  always_comb begin
    case (st_next)
      ST_FAST, ST_F_CMD: proc_next = fast_lvl;
      ST_SLOW, ST_S_CMD: proc_next = bclk_src;
      default: proc_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= ST_FAST;
      proc_reg <= 1'b0;
      proc_prev_reg <= 1'b0;
      bclk_reg <= 1'b0;
      bclk_prev_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      proc_reg <= proc_next;
      proc_prev_reg <= proc_reg;
      bclk_reg <= bclk_src;
      bclk_prev_reg <= bclk_reg;
    end
  end

  // Phase clock kept aligned by clearing it during CPU reset
  always_ff @(posedge clk_in) begin
    if (rst_in || cpu_reset_reg) begin
      phase_reg <= 1'b0;
    end else if (proc_rise) begin
      phase_reg <= ~phase_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_sys_clk_reg <= 1'b0;
    end else if (bclk_rise) begin
      bus_sys_clk_reg <= ~bus_sys_clk_reg;
    end
  end

  assign processor_clock_out = proc_reg;
  assign phase_clock_out = phase_reg;
  assign bus_state_clock_out = bclk_reg;
  assign bus_system_clock_out = bus_sys_clk_reg;

  // ******************************************************************
  // Reset generation
  // ******************************************************************
  logic soft_rise;
  logic cpu_trig;

  assign soft_rise = wr_en && (apb_req_in.paddr == RCS_CTRL_OFFSET) &&
                     apb_req_in.pwdata[RCS_CPU_RESET_REQ_POS] && !soft_req_reg;

  // Pending requests; a new request wins over its own release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      soft_pend_reg <= 1'b0;
      shut_pend_reg <= 1'b0;
    end else begin
      soft_pend_reg <= soft_rise | (soft_pend_reg & io_active);
      shut_pend_reg <= shut_rise | (shut_pend_reg & ~proc_rise);
    end
  end

  assign cpu_trig = warm_rise | (shut_pend_reg & proc_rise)
                    | (soft_pend_reg & ~io_active);

  // Width counted in processor clock rises; retrigger restarts it
  always_ff @(posedge clk_in) begin
    if (rst_in || pwr_bad || cpu_trig) begin
      rst_cnt_reg <= RST_LOAD;
      cpu_reset_reg <= 1'b1;
    end else if (proc_rise && rst_cnt_reg != CNT_ZERO) begin
      rst_cnt_reg <= rst_cnt_reg - CNT_ONE;
      cpu_reset_reg <= (rst_cnt_reg != CNT_ONE);
    end
  end

  // System reset asserts at once, releases on a processor clock rise
  always_ff @(posedge clk_in) begin
    if (rst_in || pwr_bad) begin
      sys_reset_reg <= 1'b1;
    end else if (proc_rise) begin
      sys_reset_reg <= 1'b0;
    end
  end

  assign cpu_reset_out = cpu_reset_reg;
  assign system_reset_out = sys_reset_reg;

  // ******************************************************************
  // Checks
  // ******************************************************************
  logic [RCS_RESET_CNT_W-1:0] width_reg;
  localparam logic [RCS_RESET_CNT_W-1:0] W_MAX = '1;

  always_ff @(posedge clk_in) begin
    if (rst_in || !cpu_reset_reg) begin
      width_reg <= CNT_ZERO;
    end else if (proc_rise && width_reg != W_MAX) begin
      width_reg <= width_reg + CNT_ONE;
    end
  end

  sequence s_fast_cut;
    (st_reg == ST_F_CMD) && proc_fall;
  endsequence
  sequence s_held_low;
    !proc_reg [*2];
  endsequence

  a_power_cpu_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    pwr_bad |=> cpu_reset_out && system_reset_out)
    else $error("power bad did not assert both resets");
  a_warm_cpu_only: assert property (@(posedge clk_in) disable iff (rst_in)
    warm_rise && !pwr_bad && !system_reset_out |=> cpu_reset_out && !system_reset_out)
    else $error("warm reset misbehaved");
  a_shutdown_on_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    shut_pend_reg && proc_rise |=> cpu_reset_out)
    else $error("shutdown reset missing");
  a_soft_after_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    soft_pend_reg && !io_active |=> cpu_reset_out && !soft_pend_reg)
    else $error("soft reset not issued after idle");
  a_reset_width_min: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(cpu_reset_out) |-> width_reg >= RST_LOAD)
    else $error("CPU reset too short");
  a_sys_reset_held: assert property (@(posedge clk_in) disable iff (rst_in)
    $fell(system_reset_out) |-> $past(proc_rise) && !$past(pwr_bad))
    else $error("system reset released off edge or while power bad");
  a_phase_half_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    proc_rise && !cpu_reset_reg |=> phase_clock_out != $past(phase_clock_out))
    else $error("phase clock did not toggle");
  a_bus_sys_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    bclk_rise |=> bus_system_clock_out != $past(bus_system_clock_out))
    else $error("bus system clock did not toggle");
  a_fast_cut_low: assert property (@(posedge clk_in) disable iff (rst_in)
    s_fast_cut |=> (st_reg == ST_F_GAP) ##0 s_held_low)
    else $error("fast source not removed while low");
  a_slow_resample: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_reg == ST_F_GAP) && !bclk_rise |=> st_reg == ST_F_GAP)
    else $error("bus clock enabled without low sample");
  a_fast_enable: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_reg == ST_F_ARM) && fast_fall |=> st_reg == ST_FAST)
    else $error("fast source not enabled");
  a_gap_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (st_reg == ST_F_GAP) || (st_reg == ST_S_GAP) |-> !processor_clock_out)
    else $error("processor clock high in gap");

endmodule
`default_nettype wire

/* testbench.sv */
/*
  Self-checking bench for the reset and clock select block: APB tasks,
  rise counters on the generated clocks and directed scenarios.
  Assumes the far-side model supplies both input clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rcs_pkg::*;
  localparam int N = 16;
  localparam int W = 800;
  localparam int MAXPH = 80;
  logic clk, rst, pgood, warm, io, shut, fclk, xclk, io_hold, shut_req;
  rcs_apb_req_type req;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, first;
  logic cpu_rst, sys_rst, pclk, phclk, bclk, sclk;
  logic [5:0] lv, prev = 6'h00;
  int cnt[6] = '{default: 0};
  int m[6];
  int num_errors = 0;
  int num_checks = 0;
  int hold_cnt = 0;
  int last_hold, run, min_ph, max_ph, exp;
  assign lv = {xclk, fclk, sclk, bclk, phclk, pclk};

  rcs_reset_clock_select #(.CPU_RESET_CYCLES(N)) rcs_reset_clock_select_inst (
    .clk_in(clk), .rst_in(rst), .apb_req_in(req), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .power_good_in(pgood),
    .warm_reset_in(warm), .shutdown_in(shut), .io_command_active_in(io),
    .fast_clock_in(fclk), .bus_crystal_clock_in(xclk), .cpu_reset_out(cpu_rst),
    .system_reset_out(sys_rst), .processor_clock_out(pclk),
    .phase_clock_out(phclk), .bus_state_clock_out(bclk),
    .bus_system_clock_out(sclk));
  rcs_far_side rcs_far_side_inst (
    .processor_clock_in(pclk), .io_hold_in(io_hold),
    .shutdown_req_in(shut_req), .fast_clock_out(fclk),
    .bus_crystal_clock_out(xclk), .io_command_active_out(io),
    .shutdown_out(shut));

  // ********
  // Monitors
  // ********
  // Rise counts, processor phase lengths and reset pulse length
  always @(posedge clk) begin
    for (int i = 0; i < 6; i++)
      if (lv[i] && !prev[i]) cnt[i]++;
    if (lv[0] != prev[0]) begin
      if (!first && run < min_ph) min_ph = run;
      if (!first && run > max_ph) max_ph = run;
      first = 1'b0;
      run = 1;
    end else begin
      run++;
    end
    if (cpu_rst === 1'b1 && lv[0] && !prev[0]) hold_cnt++;
    if (cpu_rst === 1'b0 && hold_cnt != 0) begin
      last_hold = hold_cnt;
      hold_cnt = 0;
    end
    prev <= lv;
  end

  // ********
  // Tasks
  // ********
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic fail_wait(input string what);
    num_errors++;
    $display("unexpected at %0t: timeout on %s", $time, what);
    print_verdict();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, want);
    end
  endtask
  task automatic check_bit(input logic got, input logic want, input string what);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, got, want);
    end
  endtask
  task automatic check_near(input int got, input int lo, input int hi, input string what);
    num_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("unexpected at %0t: %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) fail_wait("pready");
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wait_for(input int which, input logic val, input int lim);
    int n;
    n = 0;
    while ((which == 0 ? cpu_rst : sys_rst) !== val) begin
      @(posedge clk);
      n++;
      if (n > lim) fail_wait("reset level");
    end
    // One more edge so the monitor has logged the pulse length
    @(posedge clk);
  endtask
  // Polls status until the switch has settled on the wanted source
  task automatic wait_switch(input logic slow);
    int n;
    n = 0;
    do begin
      apb(1'b0, RCS_STAT_OFFSET, 32'h0);
      n++;
      if (n > 300) fail_wait("clock switch");
    end while (rd[RCS_STAT_BUSY_POS] !== 1'b0 || rd[RCS_STAT_ON_SLOW_POS] !== slow);
  endtask
  task automatic measure;
    int s[6];
    s = cnt;
    repeat (W) @(posedge clk);
    foreach (m[i]) m[i] = cnt[i] - s[i];
  endtask

  // ********
  // Scenarios
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    pgood = 1'b0;
    warm = 1'b0;
    io_hold = 1'b0;
    shut_req = 1'b0;
    first = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, RCS_SEL_OFFSET, 32'h0);
    check(rd, {30'h0, RCS_SEL_RESET}, "select default");
    apb(1'b0, RCS_CTRL_OFFSET, 32'h0);
    check_bit(rd[RCS_CLOCK_SWITCH_POS], RCS_SWITCH_RESET, "switch default");
    apb(1'b0, 12'hFFC, 32'h0);
    check_bit(err, 1'b1, "unmapped error");
    check_bit(cpu_rst & sys_rst, 1'b1, "resets while power bad");
    pgood <= 1'b1;
    wait_for(1, 1'b0, 400);
    wait_for(0, 1'b0, 3000);
    check_near(last_hold, N, 100000, "power-up cpu reset");
    $display("power-up test done");
    // Every bus clock selection while the processor stays on fast
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, RCS_SEL_OFFSET, 32'(s));
      apb(1'b0, RCS_SEL_OFFSET, 32'h0);
      check(rd, 32'(s), "select readback");
      measure();
      exp = (s == 0) ? m[4] : (s == 2) ? m[5] : m[4] / 2;
      check_near(m[2], exp - 2, exp + 2, "bus state rate");
      check_near(m[3], m[2] / 2 - 1, m[2] / 2 + 1, "bus system rate");
      check_near(m[0], m[4] - 2, m[4] + 2, "processor on fast");
      check_near(m[1], m[0] / 2 - 1, m[0] / 2 + 1, "phase rate");
    end
    $display("clock select test done");
    // Switch to crystal and to half fast, then back to fast
    for (int k = 0; k < 2; k++) begin
      first = 1'b1;
      min_ph = 1000;
      max_ph = 0;
      apb(1'b1, RCS_SEL_OFFSET, k ? 32'h1 : 32'h2);
      apb(1'b1, RCS_CTRL_OFFSET, 32'h1 << RCS_CLOCK_SWITCH_POS);
      wait_switch(1'b1);
      measure();
      exp = k ? m[4] / 2 : m[5];
      check_near(m[0], exp - 2, exp + 2, "processor on slow");
      apb(1'b1, RCS_CTRL_OFFSET, 32'h0);
      wait_switch(1'b0);
      measure();
      check_near(m[0], m[4] - 2, m[4] + 2, "processor back on fast");
      check_near(min_ph, 3, MAXPH, "shortest phase");
      check_near(max_ph, 3, MAXPH, "longest phase");
    end
    $display("clock switch test done");
    // Warm reset then shutdown: cpu reset only
    for (int k = 0; k < 2; k++) begin
      last_hold = 0;
      warm <= (k == 0);
      shut_req <= (k == 1);
      repeat (20) @(posedge clk);
      warm <= 1'b0;
      shut_req <= 1'b0;
      wait_for(0, 1'b1, 60);
      check_bit(sys_rst, 1'b0, "system reset untouched");
      wait_for(0, 1'b0, 2000);
      check_near(last_hold, N, N + 3, "cpu reset length");
    end
    $display("warm and shutdown test done");
    // Software request waits for the I/O command to end
    io_hold <= 1'b1;
    repeat (20) @(posedge clk);
    last_hold = 0;
    apb(1'b1, RCS_CTRL_OFFSET, 32'h1 << RCS_CPU_RESET_REQ_POS);
    repeat (100) @(posedge clk);
    check_bit(cpu_rst, 1'b0, "held off by io command");
    apb(1'b0, RCS_STAT_OFFSET, 32'h0);
    check_bit(rd[RCS_STAT_SOFT_PEND_POS], 1'b1, "request pending");
    io_hold <= 1'b0;
    wait_for(0, 1'b1, 60);
    wait_for(0, 1'b0, 2000);
    check_near(last_hold, N, N + 3, "soft cpu reset length");
    apb(1'b1, RCS_CTRL_OFFSET, 32'h1 << RCS_CPU_RESET_REQ_POS);
    repeat (100) @(posedge clk);
    check_bit(cpu_rst, 1'b0, "no edge no reset");
    apb(1'b1, RCS_CTRL_OFFSET, 32'h0);
    $display("soft reset test done");
    // Power failure in mid-run
    pgood <= 1'b0;
    wait_for(1, 1'b1, 20);
    repeat (2) @(posedge clk);
    check_bit(cpu_rst, 1'b1, "cpu reset on power bad");
    repeat (300) @(posedge clk);
    check_bit(sys_rst, 1'b1, "system reset held");
    apb(1'b0, RCS_STAT_OFFSET, 32'h0);
    check_bit(rd[RCS_STAT_CPU_RESET_POS] & rd[RCS_STAT_SYS_RESET_POS], 1'b1, "status resets");
    pgood <= 1'b1;
    wait_for(1, 1'b0, 400);
    wait_for(0, 1'b0, 3000);
    check_near(last_hold, N, 100000, "cpu reset after power fail");
    $display("power fail test done");
    print_verdict();
  end
endmodule
`default_nettype wire
